/* hdl/dct_pkg.sv */
// package for the dual counter/timer block: modes, field layouts, constants
// assumes one system clock domain; register access is by plain ports
package dct_pkg;

  // timer modes held in the two-bit mode field
  typedef enum logic [1:0] {
    DCT_MODE_13BIT  = 2'h0,
    DCT_MODE_16BIT  = 2'h1,
    DCT_MODE_RELOAD = 2'h2,
    DCT_MODE_IDLE   = 2'h3
  } dct_mode_t;

  // per-timer nibble of the mode register: gate, counter select, mode
  typedef struct packed {
    logic      gate_select;
    logic      counter_select;
    dct_mode_t mode;
  } dct_tmode_t;

  // byte write strobes with data for one timer's count register
  typedef struct packed {
    logic       wr_low;
    logic       wr_high;
    logic [7:0] wdata;
  } dct_cnt_wr_t;

  // pre-scaler select codes and division ratios
  localparam logic [1:0] DCT_SCALE_DIV12 = 2'h0;
  localparam logic [1:0] DCT_SCALE_DIV4  = 2'h1;
  localparam logic [1:0] DCT_SCALE_DIV48 = 2'h2;
  localparam int         DCT_DIV12       = 12;
  localparam int         DCT_DIV4        = 4;
  localparam int         DCT_DIV48       = 48;
  localparam int         DCT_PRE_W       = 6;

  // mode register bit positions for timer a (timer b sits four bits higher)
  localparam int DCT_TIMER_MODE_REG_MODE_LSB = 0;
  localparam int DCT_TIMER_MODE_REG_CT_BIT   = 2;
  localparam int DCT_TIMER_MODE_REG_GATE_BIT = 3;
  localparam int DCT_TIMER_MODE_REG_B_OFFSET = 4;

  // control register bit positions
  localparam int DCT_TIMER_CONTROL_REG_RUN_A  = 4;
  localparam int DCT_TIMER_CONTROL_REG_OVF_A  = 5;
  localparam int DCT_TIMER_CONTROL_REG_RUN_B  = 6;
  localparam int DCT_TIMER_CONTROL_REG_OVF_B  = 7;
  // clock control register bit positions
  localparam int DCT_CLOCK_CONTROL_REG_CLK_A = 3;
  localparam int DCT_CLOCK_CONTROL_REG_CLK_B = 4;

  // reset values and count limits
  localparam logic [15:0] DCT_COUNT_RESET = 16'h0000;
  localparam logic [12:0] DCT_MAX13       = 13'h1fff;
  localparam logic [7:0]  DCT_MAX8        = 8'hff;

endpackage : dct_pkg

/* hdl/dct_prescaler.sv */
// shared pre-scaler: one-cycle tick every 12, 4 or 48 system clocks
// assumes the select input is steady between changes by software
`timescale 1ns/1ns
module dct_prescaler
  import dct_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [1:0] prescale_select,
  output logic            tick
);

  logic [DCT_PRE_W-1:0] count;
  logic [DCT_PRE_W-1:0] limit;
  logic                 wrap;

  // terminal count per select; code 11 falls back to divide by 12
  assign limit = (prescale_select == DCT_SCALE_DIV4)  ? DCT_PRE_W'(DCT_DIV4 - 1)  :
                 (prescale_select == DCT_SCALE_DIV48) ? DCT_PRE_W'(DCT_DIV48 - 1) :
                                                        DCT_PRE_W'(DCT_DIV12 - 1);
  assign wrap  = (count >= limit);

  // free-running divider; >= makes a shrinking limit recover at once
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= wrap ? '0 : count + DCT_PRE_W'(1);
      tick  <= wrap;
    end
  end

endmodule : dct_prescaler

/* hdl/dct_input_sync.sv */
// two-stage synchroniser plus falling edge detect for one external input
// assumes the far side holds each level at least two system clocks
`timescale 1ns/1ns
module dct_input_sync
  import dct_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);

  logic meta;
  logic prev;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta  <= 1'b1;
      level <= 1'b1;
      prev  <= 1'b1;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  // falling edge from two successive synchronised samples
  assign fall = prev & ~level;

endmodule : dct_input_sync

/* hdl/dct_timers.sv */
// dual 8051-style counter/timer pair with 13-bit, 16-bit and 8-bit reload modes
// assumes all inputs synchronous to clock except the pins, which are synchronised here
// Behaviour
// - each timer holds a 16-bit count written and read as a low byte and a high byte.
// - each timer takes its mode from its own two-bit field; run and overflow sit in control.
// - 13-bit mode uses the high byte plus low bits 4..0; low bits 7..5 are don't care.
// - a 13-bit roll-over from 0x1fff to 0 sets the timer's overflow flag.
// - with counter select set the timer counts falling edges of its event pin.
// - in timer operation clock select 1 counts system clocks, 0 counts the pre-scaled tick.
// - the pre-scaler divides the system clock by 12, 4 or 48 per the scale select.
// - counter operation increments once per falling edge, up to a quarter of the clock rate.
// - a timer counts only when run is set and gate is clear or the gating input is active.
// - timer b uses the second gating input with its own polarity, otherwise like timer a.
// - setting run leaves the count untouched; counting resumes from the held value.
// - 16-bit mode uses all sixteen bits with the same enabling and sets overflow on roll-over.
// - 8-bit reload mode counts the low byte and reloads it from the high byte on overflow.
// - an overflow requests an interrupt only when that timer's enable bit is set.
`timescale 1ns/1ns
module dct_timers
  import dct_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  timer_mode_reg,
  input  wire logic        run_bit_a,
  input  wire logic        run_bit_b,
  input  wire logic        clock_select_a,
  input  wire logic        clock_select_b,
  input  wire logic [1:0]  prescale_select,
  input  wire logic        gating_polarity_a,
  input  wire logic        gating_polarity_b,
  input  wire logic        irq_enable_a,
  input  wire logic        irq_enable_b,
  input  wire logic        event_pin_a,
  input  wire logic        event_pin_b,
  input  wire logic        gating_input_a,
  input  wire logic        gating_input_b,
  input  wire dct_cnt_wr_t count_wr_a,
  input  wire dct_cnt_wr_t count_wr_b,
  input  wire logic        clear_overflow_a,
  input  wire logic        clear_overflow_b,
  output logic [7:0]       count_low_byte_a,
  output logic [7:0]       count_high_byte_a,
  output logic [7:0]       count_low_byte_b,
  output logic [7:0]       count_high_byte_b,
  output logic             overflow_flag_a,
  output logic             overflow_flag_b,
  output logic             irq_request_a,
  output logic             irq_request_b
);

  // split mode register into per-timer fields
  dct_tmode_t tmode_a;
  dct_tmode_t tmode_b;
  assign tmode_a = dct_tmode_t'(timer_mode_reg[DCT_TIMER_MODE_REG_B_OFFSET-1:0]);
  assign tmode_b = dct_tmode_t'(timer_mode_reg[7:DCT_TIMER_MODE_REG_B_OFFSET]);

  // shared pre-scaler and input conditioning
  logic pre_tick;
  logic ev_fall_a;
  logic ev_fall_b;
  logic gate_lvl_a;
  logic gate_lvl_b;

  dct_prescaler u_pre (
    .clock           (clock),
    .rst_n           (rst_n),
    .prescale_select (prescale_select),
    .tick            (pre_tick)
  );

  dct_input_sync u_ev_a (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (event_pin_a),
    .level (),
    .fall  (ev_fall_a)
  );

  dct_input_sync u_ev_b (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (event_pin_b),
    .level (),
    .fall  (ev_fall_b)
  );

  dct_input_sync u_gt_a (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (gating_input_a),
    .level (gate_lvl_a),
    .fall  ()
  );

  dct_input_sync u_gt_b (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (gating_input_b),
    .level (gate_lvl_b),
    .fall  ()
  );

  // enable: run and (no gate or gating input at its chosen level)
  logic enable_a;
  logic enable_b;
  assign enable_a = run_bit_a &
                    (~tmode_a.gate_select | (gate_lvl_a == gating_polarity_a));
  assign enable_b = run_bit_b &
                    (~tmode_b.gate_select | (gate_lvl_b == gating_polarity_b));

  // count source: pin falls, or system clock / pre-scaled tick
  logic inc_a;
  logic inc_b;
  assign inc_a = enable_a & (tmode_a.counter_select ? ev_fall_a
                             : (clock_select_a ? 1'b1 : pre_tick));
  assign inc_b = enable_b & (tmode_b.counter_select ? ev_fall_b
                             : (clock_select_b ? 1'b1 : pre_tick));

  // next count and overflow per mode for each timer
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic [15:0] next_cnt_a;
  logic [15:0] next_cnt_b;
  logic        ovf_a;
  logic        ovf_b;

  always_comb
  begin
    next_cnt_a = cnt_a;
    ovf_a      = 1'b0;
    if (inc_a)
    begin
      case (tmode_a.mode)
        DCT_MODE_13BIT:
        begin
          ovf_a      = ({cnt_a[15:8], cnt_a[4:0]} == DCT_MAX13);
          if (!ovf_a)
            next_cnt_a = (cnt_a[4:0] == 5'h1f)
                         ? {cnt_a[15:8] + 8'h01, cnt_a[7:5], 5'h00}
                         : {cnt_a[15:5], cnt_a[4:0] + 5'h01};
          else
            next_cnt_a = {8'h00, cnt_a[7:5], 5'h00};
        end
        DCT_MODE_16BIT:
        begin
          ovf_a      = (cnt_a == 16'hffff);
          next_cnt_a = cnt_a + 16'h0001;
        end
        DCT_MODE_RELOAD:
        begin
          ovf_a      = (cnt_a[7:0] == DCT_MAX8);
          next_cnt_a = ovf_a ? {cnt_a[15:8], cnt_a[15:8]}
                             : {cnt_a[15:8], cnt_a[7:0] + 8'h01};
        end
        default: next_cnt_a = cnt_a;  // split mode not built: holds
      endcase
    end
  end

  always_comb
  begin
    next_cnt_b = cnt_b;
    ovf_b      = 1'b0;
    if (inc_b)
    begin
      case (tmode_b.mode)
        DCT_MODE_13BIT:
        begin
          ovf_b = ({cnt_b[15:8], cnt_b[4:0]} == DCT_MAX13);
          if (!ovf_b)
            next_cnt_b = (cnt_b[4:0] == 5'h1f)
                         ? {cnt_b[15:8] + 8'h01, cnt_b[7:5], 5'h00}
                         : {cnt_b[15:5], cnt_b[4:0] + 5'h01};
          else
            next_cnt_b = {8'h00, cnt_b[7:5], 5'h00};
        end
        DCT_MODE_16BIT:
        begin
          ovf_b      = (cnt_b == 16'hffff);
          next_cnt_b = cnt_b + 16'h0001;
        end
        DCT_MODE_RELOAD:
        begin
          ovf_b      = (cnt_b[7:0] == DCT_MAX8);
          next_cnt_b = ovf_b ? {cnt_b[15:8], cnt_b[15:8]}
                             : {cnt_b[15:8], cnt_b[7:0] + 8'h01};
        end
        default: next_cnt_b = cnt_b;  // mode 3 stops timer b
      endcase
    end
  end

  // software byte writes win over a count in the same cycle; run never touches the count
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_a <= DCT_COUNT_RESET;
      cnt_b <= DCT_COUNT_RESET;
    end
    else
    begin
      cnt_a[7:0]  <= count_wr_a.wr_low  ? count_wr_a.wdata : next_cnt_a[7:0];
      cnt_a[15:8] <= count_wr_a.wr_high ? count_wr_a.wdata : next_cnt_a[15:8];
      cnt_b[7:0]  <= count_wr_b.wr_low  ? count_wr_b.wdata : next_cnt_b[7:0];
      cnt_b[15:8] <= count_wr_b.wr_high ? count_wr_b.wdata : next_cnt_b[15:8];
    end
  end

  assign count_low_byte_a  = cnt_a[7:0];
  assign count_high_byte_a = cnt_a[15:8];
  assign count_low_byte_b  = cnt_b[7:0];
  assign count_high_byte_b = cnt_b[15:8];

  // sticky overflow flags: a new overflow beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overflow_flag_a <= 1'b0;
      overflow_flag_b <= 1'b0;
      irq_request_a   <= 1'b0;
      irq_request_b   <= 1'b0;
    end
    else
    begin
      overflow_flag_a <= ovf_a | (overflow_flag_a & ~clear_overflow_a);
      overflow_flag_b <= ovf_b | (overflow_flag_b & ~clear_overflow_b);
      irq_request_a   <= irq_enable_a & (ovf_a | (overflow_flag_a & ~clear_overflow_a));
      irq_request_b   <= irq_enable_b & (ovf_b | (overflow_flag_b & ~clear_overflow_b));
    end
  end

  // ---- checks ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_wrap16_a;
    inc_a && tmode_a.mode == DCT_MODE_16BIT && cnt_a == 16'hffff
      && !count_wr_a.wr_low && !count_wr_a.wr_high;
  endsequence

  AST_OVF16_A: assert property (s_wrap16_a |=> overflow_flag_a && cnt_a == 16'h0000)
    else $error("16-bit wrap did not clear count and set flag");

  AST_RELOAD_A: assert property (
    inc_a && tmode_a.mode == DCT_MODE_RELOAD && cnt_a[7:0] == 8'hff
      && !count_wr_a.wr_low && !count_wr_a.wr_high
    |=> cnt_a[7:0] == $past(cnt_a[15:8]) && cnt_a[15:8] == $past(cnt_a[15:8]) && overflow_flag_a)
    else $error("reload mode overflow wrong");

  AST_WRAP13_B: assert property (
    inc_b && tmode_b.mode == DCT_MODE_13BIT && cnt_b[15:8] == 8'hff && cnt_b[4:0] == 5'h1f
      && !count_wr_b.wr_low && !count_wr_b.wr_high
    |=> overflow_flag_b && cnt_b[15:8] == 8'h00 && cnt_b[4:0] == 5'h00)
    else $error("13-bit wrap wrong");

  AST_HOLD_STOPPED_A: assert property (
    !run_bit_a && !count_wr_a.wr_low && !count_wr_a.wr_high |=> $stable(cnt_a))
    else $error("timer a moved while stopped");

  AST_GATE_B: assert property (
    tmode_b.gate_select && gate_lvl_b != gating_polarity_b
      && !count_wr_b.wr_low && !count_wr_b.wr_high |=> $stable(cnt_b))
    else $error("timer b moved while gated off");

  AST_SYSTEM_CLOCK_A: assert property (
    run_bit_a && !tmode_a.gate_select && !tmode_a.counter_select && clock_select_a
      && tmode_a.mode == DCT_MODE_16BIT && cnt_a != 16'hffff
      && !count_wr_a.wr_low && !count_wr_a.wr_high
    |=> cnt_a == $past(cnt_a) + 16'h0001)
    else $error("timer a missed a system clock count");

  AST_EVENT_A: assert property (
    tmode_a.counter_select && !ev_fall_a && !count_wr_a.wr_low && !count_wr_a.wr_high
    |=> $stable(cnt_a))
    else $error("counter a moved without a falling edge");

  AST_IRQ_A: assert property (irq_request_a |-> $past(irq_enable_a))
    else $error("interrupt without enable");

  AST_FLAG_KEEP_B: assert property (
    overflow_flag_b && !clear_overflow_b |=> overflow_flag_b)
    else $error("overflow b lost without a clear");

  // the pulse must trace back to a high-then-low pair on the raw pin, three and two edges earlier
  AST_FALL_A: assert property (
    ev_fall_a |-> ($past(event_pin_a, 3) && !$past(event_pin_a, 2)) ##1 !ev_fall_a)
    else $error("edge detect does not follow the event pin");

  // a clear with no new overflow must drop the flag and the request together
  sequence s_clear_a;
    overflow_flag_a && clear_overflow_a && !ovf_a;
  endsequence

  AST_CLEAR_A: assert property (s_clear_a |=> !overflow_flag_a && !irq_request_a)
    else $error("overflow a survived a clear");

  AST_IRQ_OFF_B: assert property (!irq_enable_b |=> !irq_request_b)
    else $error("interrupt b raised while disabled");

  AST_RELOAD_HIGH_B: assert property (
    inc_b && tmode_b.mode == DCT_MODE_RELOAD && !count_wr_b.wr_high
    |=> cnt_b[15:8] == $past(cnt_b[15:8]))
    else $error("reload b altered its reload byte");

endmodule : dct_timers

/* tb/dct_pin_model.sv */
// far-side model: event pins and gating inputs of both timers
// assumes the bench calls its tasks from one clocked sequence
`timescale 1ns/1ns
module dct_pin_model
  import dct_pkg::*;
(
  input  wire logic clock,
  output logic      event_pin_a,
  output logic      event_pin_b,
  output logic      gating_input_a,
  output logic      gating_input_b
);
  // event lines idle high so the first edge seen is a fall
  initial
  begin
    event_pin_a    = 1'h1;
    event_pin_b    = 1'h1;
    gating_input_a = 1'h0;
    gating_input_b = 1'h0;
  end

  // n falls on both event pins, each level held for hold clocks
  task automatic pulses(input int n, input int hold);
    repeat (n)
    begin
      @(posedge clock);
      event_pin_a <= 1'h0;
      event_pin_b <= 1'h0;
      repeat (hold) @(posedge clock);
      event_pin_a <= 1'h1;
      event_pin_b <= 1'h1;
      repeat (hold - 1) @(posedge clock);
    end
  endtask : pulses

  // gating levels change just after an edge, never mid-cycle
  task automatic set_gate(input logic a, input logic b);
    @(posedge clock);
    gating_input_a <= a;
    gating_input_b <= b;
  endtask : set_gate
endmodule : dct_pin_model

/* tb/dct_timers_tb.sv */
// self-checking bench for the dual counter/timer pair
// assumes plain-port control and the pin model on the far side
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module dct_timers_tb
  import dct_pkg::*;
;
  logic        clock;
  logic        rst_n;
  dct_tmode_t  tm_a;
  dct_tmode_t  tm_b;
  logic        run_a, run_b, clk_a, clk_b, clr_a, clr_b;
  logic [1:0]  prescale_select;
  logic        pol_a, pol_b, ien_a, ien_b;
  logic        ev_a, ev_b, gin_a, gin_b;
  dct_cnt_wr_t wr_a, wr_b;
  logic [7:0]  low_a, high_a, low_b, high_b;
  logic        flag_a, flag_b, irq_a, irq_b;
  int          fails, num_checks, exp_cnt;

  dct_pin_model u_pins (.clock(clock), .event_pin_a(ev_a), .event_pin_b(ev_b),
    .gating_input_a(gin_a), .gating_input_b(gin_b));

  dct_timers u_dut (.clock(clock), .rst_n(rst_n), .timer_mode_reg({tm_b, tm_a}),
    .run_bit_a(run_a), .run_bit_b(run_b), .clock_select_a(clk_a), .clock_select_b(clk_b),
    .prescale_select(prescale_select), .gating_polarity_a(pol_a), .gating_polarity_b(pol_b),
    .irq_enable_a(ien_a), .irq_enable_b(ien_b), .event_pin_a(ev_a), .event_pin_b(ev_b),
    .gating_input_a(gin_a), .gating_input_b(gin_b), .count_wr_a(wr_a), .count_wr_b(wr_b),
    .clear_overflow_a(clr_a), .clear_overflow_b(clr_b), .count_low_byte_a(low_a),
    .count_high_byte_a(high_a), .count_low_byte_b(low_b), .count_high_byte_b(high_b),
    .overflow_flag_a(flag_a), .overflow_flag_b(flag_b), .irq_request_a(irq_a),
    .irq_request_b(irq_b));

  // 100 MHz system clock
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic end_test(input string nm);
    $display("test %s done, mismatches so far %0d", nm, fails);
  endtask : end_test

  // both timers get the same mode bits except where a scenario splits them
  task automatic cfg(input dct_mode_t ma, input dct_mode_t mb, input logic ct,
                     input logic ca, input logic cb, input logic g);
    @(posedge clock);
    tm_a  <= '{gate_select: g, counter_select: ct, mode: ma};
    tm_b  <= '{gate_select: g, counter_select: ct, mode: mb};
    clk_a <= ca;
    clk_b <= cb;
  endtask : cfg

  // low byte then high byte, one strobe cycle each
  task automatic load(input logic [15:0] a, input logic [15:0] b);
    @(posedge clock);
    wr_a <= '{wr_low: 1'h1, wr_high: 1'h0, wdata: a[7:0]};
    wr_b <= '{wr_low: 1'h1, wr_high: 1'h0, wdata: b[7:0]};
    @(posedge clock);
    wr_a <= '{wr_low: 1'h0, wr_high: 1'h1, wdata: a[15:8]};
    wr_b <= '{wr_low: 1'h0, wr_high: 1'h1, wdata: b[15:8]};
    @(posedge clock);
    wr_a <= '0;
    wr_b <= '0;
  endtask : load

  task automatic set_run(input logic v);
    @(posedge clock);
    run_a <= v;
    run_b <= v;
  endtask : set_run

  // run bits high for exactly n sampling edges, then let results settle
  task automatic run_n(input int n);
    set_run(1'h1);
    repeat (n - 1) @(posedge clock);
    set_run(1'h0);
    repeat (2) @(posedge clock);
  endtask : run_n

  task automatic clear_flags;
    @(posedge clock);
    clr_a <= 1'h1;
    clr_b <= 1'h1;
    @(posedge clock);
    clr_a <= 1'h0;
    clr_b <= 1'h0;
    repeat (2) @(posedge clock);
    `CHK("flag_a", 1'h0, flag_a);
    `CHK("flag_b", 1'h0, flag_b);
  endtask : clear_flags

  task automatic chk_both(input logic [15:0] ea, input logic [15:0] eb);
    `CHK("count_a", ea, {high_a, low_a});
    `CHK("count_b", eb, {high_b, low_b});
  endtask : chk_both

  // hang guard: a run this long means something stalled
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    finish_test;
  end

  initial
  begin
    fails = 0; num_checks = 0; exp_cnt = 0;
    rst_n = 1'h0; tm_a = '0; tm_b = '0; run_a = 1'h0; run_b = 1'h0;
    clk_a = 1'h0; clk_b = 1'h0; clr_a = 1'h0; clr_b = 1'h0; prescale_select = 2'h0;
    pol_a = 1'h1; pol_b = 1'h0; ien_a = 1'h1; ien_b = 1'h0; wr_a = '0; wr_b = '0;
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    chk_both(16'h0000, 16'h0000);
    end_test("reset");
    // 16-bit roll-over; only timer a has its interrupt enabled
    cfg(DCT_MODE_16BIT, DCT_MODE_16BIT, 1'h0, 1'h1, 1'h1, 1'h0);
    load(16'hfffe, 16'hfffe);
    run_n(3);
    chk_both(16'h0001, 16'h0001);
    `CHK("flag_a", 1'h1, flag_a);
    `CHK("flag_b", 1'h1, flag_b);
    `CHK("irq_a", 1'h1, irq_a);
    `CHK("irq_b", 1'h0, irq_b);
    clear_flags;
    `CHK("irq_a", 1'h0, irq_a);
    end_test("mode16");
    // 13-bit: 0x1ffe plus three; upper low bits are not compared
    cfg(DCT_MODE_13BIT, DCT_MODE_13BIT, 1'h0, 1'h1, 1'h1, 1'h0);
    load(16'hff1e, 16'hff1e);
    run_n(3);
    `CHK("high_a", 8'h00, high_a);
    `CHK("low_a", 5'h01, low_a[4:0]);
    `CHK("low_b", 5'h01, low_b[4:0]);
    `CHK("flag_a", 1'h1, flag_a);
    clear_flags;
    end_test("mode13");
    // reload: low fe runs over to the reload value f0, then one more
    cfg(DCT_MODE_RELOAD, DCT_MODE_RELOAD, 1'h0, 1'h1, 1'h1, 1'h0);
    load(16'hf0fe, 16'hf0fe);
    run_n(3);
    chk_both(16'hf0f1, 16'hf0f1);
    `CHK("flag_a", 1'h1, flag_a);
    clear_flags;
    cfg(DCT_MODE_IDLE, DCT_MODE_IDLE, 1'h0, 1'h1, 1'h1, 1'h0);
    run_n(20);
    chk_both(16'hf0f1, 16'hf0f1);
    // modes differ per timer: same start, different outcome
    cfg(DCT_MODE_16BIT, DCT_MODE_RELOAD, 1'h0, 1'h1, 1'h1, 1'h0);
    load(16'h00ff, 16'h00ff);
    run_n(1);
    chk_both(16'h0100, 16'h0000);
    `CHK("flag_a", 1'h0, flag_a);
    `CHK("flag_b", 1'h1, flag_b);
    clear_flags;
    end_test("reload");
    // a counts system clocks, b counts the divide-by-4 tick
    cfg(DCT_MODE_16BIT, DCT_MODE_16BIT, 1'h0, 1'h1, 1'h0, 1'h0);
    prescale_select <= DCT_SCALE_DIV4;
    load(16'h0000, 16'h0000);
    run_n(8);
    chk_both(16'h0008, 16'h0002);
    // windows of 96 clocks hold whole tick periods whatever the phase
    cfg(DCT_MODE_16BIT, DCT_MODE_16BIT, 1'h0, 1'h0, 1'h0, 1'h0);
    load(16'h0000, 16'h0000);
    prescale_select <= DCT_SCALE_DIV12;
    run_n(96);
    exp_cnt = 96 / DCT_DIV12;
    chk_both(16'(exp_cnt), 16'(exp_cnt));
    prescale_select <= DCT_SCALE_DIV4;
    run_n(96);
    exp_cnt = exp_cnt + 96 / DCT_DIV4;
    chk_both(16'(exp_cnt), 16'(exp_cnt));
    prescale_select <= DCT_SCALE_DIV48;
    run_n(96);
    exp_cnt = exp_cnt + 96 / DCT_DIV48;
    chk_both(16'(exp_cnt), 16'(exp_cnt));
    end_test("prescale");
    // gate: a wants a high gating level, b a low one
    cfg(DCT_MODE_16BIT, DCT_MODE_16BIT, 1'h0, 1'h1, 1'h1, 1'h1);
    u_pins.set_gate(1'h1, 1'h1);
    load(16'h0000, 16'h0000);
    repeat (2) @(posedge clock);
    run_n(10);
    chk_both(16'h000a, 16'h0000);
    u_pins.set_gate(1'h0, 1'h0);
    repeat (4) @(posedge clock);
    run_n(10);
    chk_both(16'h000a, 16'h000a);
    end_test("gate");
    // external events at a quarter of the clock rate
    cfg(DCT_MODE_16BIT, DCT_MODE_16BIT, 1'h1, 1'h1, 1'h1, 1'h0);
    load(16'h0000, 16'h0000);
    set_run(1'h1);
    u_pins.pulses(5, 2);
    repeat (4) @(posedge clock);
    set_run(1'h0);
    repeat (2) @(posedge clock);
    chk_both(16'h0005, 16'h0005);
    end_test("events");
    finish_test;
  end
endmodule : dct_timers_tb
